// [design/boot_strap_mode_select.sv]
// Summary of operation
// - latch strap pins before internal reset release
// - strap value picks debug and serial pinout
// - strap 100 selects serial download, JTAG
// - serial download waits forever for loader
// - strap 001 runs with two-wire debug
// - strap 000 runs with four-wire JTAG
// - strap 010 checks break, then load/run
// - strap 011 starts factory restore on reset
// - restore pattern plus rising reset starts restore
// - restore settings: none, parameters, all
// - block host access to factory region
// - unfinished restore resumes after power-up
// - full restore lasts about eight seconds
// - lower straps never offered as general pins
//
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
module boot_strap_mode_select
  import boot_strap_pkg::*;
#(
  parameter int        RESTORE_LEN = RESTORE_CYCLES,
  parameter int        FRAME_LEN   = FRAME_CYCLES,
  parameter int        BREAK_WIN   = BREAK_WIN_CYCLES,
  parameter int        SETTLE_LEN  = 4
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [2:0]  boot_strap_pins,
  input  wire logic        ext_reset_pin_n,
  input  wire logic        serialRx,
  input  wire logic        restorePendingIn,
  input  wire logic        hostFlashReq,
  input  wire logic        hostInFactory,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             internalReset,
  output logic      [2:0]  bootFlow,
  output logic      [1:0]  debugMapping,
  output logic             serialPortMapped,
  output logic             strapTopFree,
  output logic             analogTestOwn,
  output logic             restoreBusy,
  output logic             restorePendingOut,
  output logic      [1:0]  restoreMode,
  output logic             hostFlashGrant
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [2:0] strapSync;
  logic       extRstSync;
  logic       rxSync;

  pin_sync #(.W(5)) u_sync (
    .clock  (clock),
    .rst    (rst),
    .pinIn  ({boot_strap_pins, ext_reset_pin_n, serialRx}),
    .pinOut ({strapSync, extRstSync, rxSync})
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode shared by power-up and restore paths

  function automatic boot_flow_t decode_flow(input logic [2:0] s);
    case (s)
      STRAP_SERIAL_DL: decode_flow = serial_download_code;
      STRAP_RUN_TWO:   decode_flow = run_two_wire_code;
      STRAP_RUN_FOUR:  decode_flow = run_four_wire_code;
      STRAP_BREAK_DET: decode_flow = break_detect_code;
      STRAP_RESTORE:   decode_flow = factory_restore_code;
      default:         decode_flow = run_four_wire_code;
    endcase
  endfunction : decode_flow

  ////////////////////////////////////////////////////////////////////////////
  // power-up sequence

  typedef enum logic [2:0] {
    ST_SETTLE, ST_LATCH, ST_BREAK, ST_RESTORE, ST_RUN, ST_LOAD
  } seq_t;

  seq_t        state_q;
  logic [2:0]  strap_q;
  logic [7:0]  settle_q;
  logic [31:0] restoreCount_q;
  logic        brkStart_q;
  logic        brkDone;
  logic        brkSeen;
  logic        extRstPrev_q;
  logic        restoreTrig;
  logic        swStart;
  logic        restoreDone_q;

  break_detect #(.FRAME(FRAME_LEN), .WINDOW(BREAK_WIN)) u_brk (
    .clock   (clock),
    .rst     (rst),
    .start   (brkStart_q),
    .rxLevel (rxSync),
    .done    (brkDone),
    .seen    (brkSeen)
  );

  // rising external reset while restore straps are held
  assign restoreTrig = !extRstPrev_q && extRstSync &&
                       strapSync == STRAP_RESTORE;

  always_ff @(posedge clock) begin
    if (rst) extRstPrev_q <= 1'b1;
    else     extRstPrev_q <= extRstSync;
  end

  // main sequencer; serial download has no exit but a new boot
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q        <= ST_SETTLE;
      strap_q        <= 3'h0;
      settle_q       <= 8'h0;
      restoreCount_q <= 32'h0;
      brkStart_q     <= 1'b0;
      internalReset  <= 1'b1;
      bootFlow       <= 3'(run_four_wire_code);
      restoreBusy    <= 1'b0;
      restoreDone_q  <= 1'b0;
    end else begin
      brkStart_q <= 1'b0;
      case (state_q)
        ST_SETTLE: begin
          // wait for synchronisers to fill before sampling
          settle_q <= settle_q + 8'h1;
          if (settle_q >= 8'(SETTLE_LEN)) state_q <= ST_LATCH;
        end
        ST_LATCH: begin
          strap_q  <= strapSync;
          bootFlow <= 3'(decode_flow(strapSync));
          if (restorePendingIn) begin
            state_q     <= ST_RESTORE;
            restoreBusy <= 1'b1;
          end else begin
            case (decode_flow(strapSync))
              serial_download_code: state_q <= ST_LOAD;
              break_detect_code: begin
                state_q    <= ST_BREAK;
                brkStart_q <= 1'b1;
              end
              default: state_q <= ST_RUN;
            endcase
          end
          internalReset <= 1'b0;
        end
        ST_BREAK: begin
          if (brkDone) begin
            state_q  <= brkSeen ? ST_LOAD : ST_RUN;
            bootFlow <= brkSeen ? 3'(serial_download_code)
                                : 3'(run_four_wire_code);
          end
        end
        ST_LOAD: begin
          state_q <= ST_LOAD;
        end
        ST_RUN: begin
          if (restoreTrig || swStart) begin
            state_q        <= ST_RESTORE;
            restoreCount_q <= 32'h0;
            restoreBusy    <= 1'b1;
            bootFlow       <= 3'(factory_restore_code);
          end
        end
        ST_RESTORE: begin
          restoreCount_q <= restoreCount_q + 32'h1;
          if (restoreCount_q >= 32'(RESTORE_LEN - 1)) begin
            state_q       <= ST_RUN;
            restoreBusy   <= 1'b0;
            restoreDone_q <= 1'b1;
            bootFlow      <= 3'(decode_flow(strap_q));
          end
        end
        default: state_q <= ST_SETTLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin mapping and protection outputs

  always_ff @(posedge clock) begin
    if (rst) begin
      debugMapping      <= DBG_FOUR_WIRE;
      serialPortMapped  <= 1'b0;
      strapTopFree      <= 1'b0;
      analogTestOwn     <= 1'b1;
      hostFlashGrant    <= 1'b0;
      restorePendingOut <= 1'b0;
    end else begin
      debugMapping <= (strap_q == STRAP_RUN_TWO) ? DBG_TWO_WIRE
                                                 : DBG_FOUR_WIRE;
      serialPortMapped  <= state_q == ST_LOAD || state_q == ST_BREAK;
      strapTopFree      <= !internalReset;
      analogTestOwn     <= 1'b1;
      hostFlashGrant    <= hostFlashReq && !hostInFactory;
      restorePendingOut <= restoreBusy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave, answers one cycle after the request

  logic        wbHit;
  logic [1:0]  mode_q;
  logic        start_q;

  assign wbHit   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign swStart = start_q && mode_q != RESTORE_NONE;

  always_ff @(posedge clock) begin
    if (rst) begin
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h0;
      mode_q      <= RESTORE_ALL;
      start_q     <= 1'b0;
      restoreMode <= RESTORE_ALL;
    end else begin
      wb_ack_o    <= wbHit;
      start_q     <= 1'b0;
      restoreMode <= mode_q;
      if (wbHit && wb_we_i && wb_adr_i[3:0] == ADDR_CONTROL &&
          wb_sel_i[0]) begin
        mode_q  <= wb_dat_i[CT_MODE_LSB +: 2];
        start_q <= wb_dat_i[CT_START_BIT];
      end
      wb_dat_o <= 32'h0;
      if (wbHit && !wb_we_i) begin
        case (wb_adr_i[3:0])
          ADDR_STATUS: begin
            wb_dat_o[ST_STRAP_LSB +: 3] <= strap_q;
            wb_dat_o[ST_FLOW_LSB +: 3]  <= bootFlow;
            wb_dat_o[ST_BUSY_BIT]       <= restoreBusy;
            wb_dat_o[ST_DONE_BIT]       <= restoreDone_q;
            wb_dat_o[ST_BREAK_BIT]      <= brkSeen;
            wb_dat_o[ST_PEND_BIT]       <= restorePendingIn;
          end
          ADDR_CONTROL: wb_dat_o[CT_MODE_LSB +: 2] <= mode_q;
          ADDR_PROGRESS: wb_dat_o <= restoreCount_q;
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_restoreArm;
    state_q == ST_RUN && restoreTrig;
  endsequence

  property p_latch_before_release;
    @(posedge clock) disable iff (rst)
    $fell(internalReset) |-> strap_q == $past(strapSync);
  endproperty
  a_latch_before_release: assert property (p_latch_before_release)
    else $error("strap not latched at reset release");

  property p_load_holds;
    @(posedge clock) disable iff (rst)
    state_q == ST_LOAD |=> state_q == ST_LOAD;
  endproperty
  a_load_holds: assert property (p_load_holds)
    else $error("serial download left without reboot");

  property p_two_wire;
    @(posedge clock) disable iff (rst)
    !internalReset && strap_q == STRAP_RUN_TWO
    |=> debugMapping == DBG_TWO_WIRE;
  endproperty
  a_two_wire: assert property (p_two_wire)
    else $error("two-wire debug not mapped");

  property p_restore_start;
    @(posedge clock) disable iff (rst)
    s_restoreArm |=> restoreBusy && state_q == ST_RESTORE;
  endproperty
  a_restore_start: assert property (p_restore_start)
    else $error("restore did not start on reset edge");

  property p_factory_block;
    @(posedge clock) disable iff (rst)
    hostInFactory |=> !hostFlashGrant;
  endproperty
  a_factory_block: assert property (p_factory_block)
    else $error("host reached factory region");

  property p_pending_resume;
    @(posedge clock) disable iff (rst)
    state_q == ST_LATCH && restorePendingIn |=> state_q == ST_RESTORE;
  endproperty
  a_pending_resume: assert property (p_pending_resume)
    else $error("pending restore not resumed");

  property p_reserved;
    @(posedge clock) disable iff (rst)
    state_q == ST_LATCH && !restorePendingIn &&
    strapSync inside {3'h5, 3'h6, 3'h7}
    |=> state_q == ST_RUN && bootFlow == 3'(run_four_wire_code);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved straps not run with jtag");

  property p_wb_ack;
    @(posedge clock) disable iff (rst)
    wbHit |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack)
    else $error("wishbone ack not one cycle");

endmodule : boot_strap_mode_select

// [design/boot_strap_pkg.sv]
package boot_strap_pkg;

  // strap codes, index 2 is the highest strap pin
  localparam logic [2:0] STRAP_SERIAL_DL  = 3'h4;
  localparam logic [2:0] STRAP_RUN_TWO    = 3'h1;
  localparam logic [2:0] STRAP_RUN_FOUR   = 3'h0;
  localparam logic [2:0] STRAP_BREAK_DET  = 3'h2;
  localparam logic [2:0] STRAP_RESTORE    = 3'h3;

  // boot flows reported to the rest of the chip
  typedef enum logic [2:0] {
    serial_download_code,
    run_two_wire_code,
    run_four_wire_code,
    break_detect_code,
    factory_restore_code
  } boot_flow_t;

  // debug pin mapping
  localparam logic [1:0] DBG_FOUR_WIRE    = 2'h0;
  localparam logic [1:0] DBG_TWO_WIRE     = 2'h1;

  // restore settings
  localparam logic [1:0] RESTORE_NONE     = 2'h0;
  localparam logic [1:0] RESTORE_PARAMS   = 2'h1;
  localparam logic [1:0] RESTORE_ALL      = 2'h2;

  // wishbone register map (byte addresses)
  localparam logic [3:0] ADDR_STATUS      = 4'h0;
  localparam logic [3:0] ADDR_CONTROL     = 4'h4;
  localparam logic [3:0] ADDR_PROGRESS    = 4'h8;

  // status field positions
  localparam int         ST_STRAP_LSB     = 0;
  localparam int         ST_FLOW_LSB      = 4;
  localparam int         ST_BUSY_BIT      = 8;
  localparam int         ST_DONE_BIT      = 9;
  localparam int         ST_BREAK_BIT     = 10;
  localparam int         ST_PEND_BIT      = 11;

  // control field positions
  localparam int         CT_MODE_LSB      = 0;
  localparam int         CT_START_BIT     = 2;
  localparam int         CT_DONE_BIT      = 3;

  // timing at 10 MHz
  localparam int         CLOCK_HZ         = 10_000_000;
  localparam int         RESTORE_MS       = 8000;
  localparam int         RESTORE_CYCLES   = RESTORE_MS * (CLOCK_HZ / 1000);
  localparam int         LOADER_BAUD      = 115_200;
  localparam int         FRAME_BITS       = 10;
  localparam int         FRAME_CYCLES     =
    (FRAME_BITS * CLOCK_HZ + LOADER_BAUD - 1) / LOADER_BAUD;
  localparam int         BREAK_WIN_US     = 10_000;
  localparam int         BREAK_WIN_CYCLES =
    BREAK_WIN_US * (CLOCK_HZ / 1_000_000);

endpackage : boot_strap_pkg

// [design/pin_sync.sv]
// two-flop synchroniser for a bundle of pin levels
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut
);
  logic [W-1:0] meta_q;

  // first stage is read only by the second stage
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_q <= '0;
      pinOut <= '0;
    end else begin
      meta_q <= pinIn;
      pinOut <= meta_q;
    end
  end
endmodule : pin_sync

// [design/break_detect.sv]
// measures a low run on the loader receive line inside a window
module break_detect
  import boot_strap_pkg::*;
#(
  parameter int FRAME  = FRAME_CYCLES,
  parameter int WINDOW = BREAK_WIN_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic rxLevel,
  output logic      done,
  output logic      seen
);
  logic [31:0] winCount_q;
  logic [31:0] lowCount_q;
  logic        active_q;

  // window and low-run counters; seen sticks once a full frame runs low
  always_ff @(posedge clock) begin
    if (rst) begin
      winCount_q <= 32'h0;
      lowCount_q <= 32'h0;
      active_q   <= 1'b0;
      done       <= 1'b0;
      seen       <= 1'b0;
    end else if (start) begin
      winCount_q <= 32'h0;
      lowCount_q <= 32'h0;
      active_q   <= 1'b1;
      done       <= 1'b0;
      seen       <= 1'b0;
    end else if (active_q) begin
      winCount_q <= winCount_q + 32'h1;
      lowCount_q <= rxLevel ? 32'h0 : lowCount_q + 32'h1;
      if (!rxLevel && lowCount_q >= 32'(FRAME)) begin
        seen     <= 1'b1;
        done     <= 1'b1;
        active_q <= 1'b0;
      end else if (winCount_q >= 32'(WINDOW - 1)) begin
        done     <= 1'b1;
        active_q <= 1'b0;
      end
    end
  end
endmodule : break_detect

// [tb/board_model.sv]
module board_model
  import boot_strap_pkg::*;
#(
  parameter int HOLD = 20
) (
  input  wire logic       clock,
  input  wire logic [2:0] strapCode,
  input  wire logic       pressReset,
  input  wire logic       sendBreak,
  output logic      [2:0] boot_strap_pins,
  output logic            ext_reset_pin_n,
  output logic            serialRx
);
  int lowCnt = 0;
  ////////////////////////////////////////////////////////////////////////
  // strap resistors; levels change ahead of a new power-up and once in download mode, and the
  // top pin is never turned round into an input that could upset sensing
  assign boot_strap_pins = strapCode;
  // external reset button, active low
  assign ext_reset_pin_n = !pressReset;
  ////////////////////////////////////////////////////////////////////////
  // loader break: line held low well past one frame, idle high by pull-up
  always_ff @(posedge clock) begin
    if (sendBreak) begin
      lowCnt <= HOLD;
    end else if (lowCnt != 0) begin
      lowCnt <= lowCnt - 1;
    end
  end
  assign serialRx = (lowCnt == 0);
endmodule : board_model

// [tb/boot_strap_mode_select_test.sv]
module boot_strap_mode_select_test
  import boot_strap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RLEN = 50;
  logic        clock = 0, rst = 1, pressReset = 0, sendBreak = 0;
  logic [2:0]  strapCode = 3'h0, bootFlow, pins;
  logic        extN, rxLine, pendIn = 0, req = 0, inFact = 0;
  logic [31:0] adr = 0, dat = 0, datO;
  logic [3:0]  sel = 4'hf;
  logic        we = 0, cyc = 0, stb = 0, ack, internalReset;
  logic [1:0]  debugMapping, restoreMode;
  logic        serialPortMapped, strapTopFree, analogTestOwn;
  logic        restoreBusy, restorePendingOut, hostFlashGrant;
  int          failures = 0, compares = 0;
  logic [31:0] rd;

  always #50 clock = ~clock;

  board_model board_model_i (.clock(clock), .strapCode(strapCode),
    .pressReset(pressReset), .sendBreak(sendBreak),
    .boot_strap_pins(pins), .ext_reset_pin_n(extN), .serialRx(rxLine));

  boot_strap_mode_select #(.RESTORE_LEN(RLEN), .FRAME_LEN(10),
    .BREAK_WIN(200)) boot_strap_mode_select_i (.clock(clock), .rst(rst),
    .boot_strap_pins(pins), .ext_reset_pin_n(extN), .serialRx(rxLine),
    .restorePendingIn(pendIn), .hostFlashReq(req), .hostInFactory(inFact),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(datO), .wb_ack_o(ack),
    .internalReset(internalReset), .bootFlow(bootFlow),
    .debugMapping(debugMapping), .serialPortMapped(serialPortMapped),
    .strapTopFree(strapTopFree), .analogTestOwn(analogTestOwn),
    .restoreBusy(restoreBusy), .restorePendingOut(restorePendingOut),
    .restoreMode(restoreMode), .hostFlashGrant(hostFlashGrant));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // single classic cycle; waits up to 50 cycles for ack, then flags a failure
  task automatic wb(input logic w, input logic [31:0] a, d);
    int n = 0;
    @(posedge clock);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    do begin @(posedge clock); n++; end while (ack !== 1'b1 && n < 50);
    rd = datO;
    cyc <= 0; stb <= 0; we <= 0;
    chk("ack", n < 50, 1);
  endtask : wb

  // power-up with the given straps; straps are set before reset ends
  task automatic boot(input logic [2:0] code, input logic pend);
    int n = 0;
    @(posedge clock);
    strapCode <= code; pendIn <= pend; rst <= 1;
    repeat (4) @(posedge clock);
    chk("inreset", internalReset, 1);
    rst <= 0;
    do begin @(posedge clock); n++; end
    while (internalReset !== 1'b0 && n < 40);
    chk("release", n < 40, 1);
  endtask : boot

  // waits for the restore to finish; checks its length in cycles
  task automatic wait_restore();
    int n = 0;
    do begin @(posedge clock); n++; end
    while (restoreBusy !== 1'b0 && n < RLEN + 20);
    chk("restlen", n >= RLEN - 2 && n <= RLEN + 3, 1);
  endtask : wait_restore

  ////////////////////////////////////////////////////////////////////////
  task automatic t_decode();
    logic [2:0] c [6] = '{3'h4, 3'h1, 3'h0, 3'h5, 3'h6, 3'h7};
    logic [2:0] fl [6] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h2, 3'h2};
    logic [1:0] dg [6] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0};
    for (int i = 0; i < 6; i++) begin
      boot(c[i], 1'b0);
      @(negedge clock);
      chk("flow", bootFlow, fl[i]);
      chk("dbg", debugMapping, dg[i]);
      chk("uart", serialPortMapped, i == 0);
      chk("analog", analogTestOwn, 1);
      chk("topfree", strapTopFree, 1);
    end
    $display("decode test done");
  endtask : t_decode

  // download mode ignores strap changes until the next power-up
  task automatic t_hold();
    boot(3'h4, 1'b0);
    strapCode <= 3'h0;
    repeat (300) @(posedge clock);
    chk("hold", bootFlow, serial_download_code);
    boot(3'h0, 1'b0);
    chk("reboot", bootFlow, run_four_wire_code);
    $display("download hold test done");
  endtask : t_hold

  // break window: once with a long low run, once with an idle line
  task automatic t_break(input logic brk);
    boot(3'h2, 1'b0);
    sendBreak <= brk;
    @(posedge clock);
    sendBreak <= 0;
    repeat (260) @(posedge clock);
    chk("brkflow", bootFlow, brk ? 3'h0 : 3'h2);
    chk("brkdbg", debugMapping, DBG_FOUR_WIRE);
    wb(1'b0, 32'h0, 32'h0);
    chk("brkbit", rd[ST_BREAK_BIT], brk);
    $display("break test done");
  endtask : t_break

  // restore from the pins: restore straps and a rising external reset
  task automatic t_pin_restore();
    int n = 0;
    boot(3'h3, 1'b0);
    pressReset <= 1;
    repeat (3) @(posedge clock);
    pressReset <= 0;
    do begin @(posedge clock); n++; end
    while (restoreBusy !== 1'b1 && n < 20);
    // pending output follows busy one cycle later; look once it has settled
    @(negedge clock);
    chk("pinbusy", restoreBusy, 1);
    chk("pend", restorePendingOut, 1);
    chk("rflow", bootFlow, factory_restore_code);
    chk("rmode", restoreMode, RESTORE_ALL);
    wait_restore();
    wb(1'b0, 32'h0, 32'h0);
    chk("done", rd[ST_DONE_BIT], 1);
    $display("pin restore test done");
  endtask : t_pin_restore

  // restore settings through the control register, plus a hole in the map
  task automatic t_reg_restore();
    boot(3'h0, 1'b0);
    wb(1'b1, 32'h4, 32'h4);
    repeat (3) @(posedge clock);
    chk("nonebusy", restoreBusy, 0);
    chk("nonemode", restoreMode, RESTORE_NONE);
    wb(1'b1, 32'h4, 32'h5);
    repeat (3) @(posedge clock);
    chk("parbusy", restoreBusy, 1);
    chk("parmode", restoreMode, RESTORE_PARAMS);
    wait_restore();
    wb(1'b0, 32'h8, 32'h0);
    chk("progress", rd, RLEN);
    wb(1'b1, 32'h4, 32'h2);
    @(negedge clock);
    chk("allmode", restoreMode, RESTORE_ALL);
    wb(1'b0, 32'h0, 32'h0);
    chk("status", rd[6:0], 7'h20);
    wb(1'b0, 32'h4, 32'h0);
    chk("ctlread", rd[1:0], RESTORE_ALL);
    wb(1'b0, 32'hc, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("register restore test done");
  endtask : t_reg_restore

  // unfinished restore from before power loss picks up on power-up
  task automatic t_resume();
    int n = 0;
    boot(3'h0, 1'b1);
    do begin @(posedge clock); n++; end
    while (restoreBusy !== 1'b1 && n < 30);
    chk("resume", restoreBusy, 1);
    // time the restore from its start, then look at the pending bit
    wait_restore();
    wb(1'b0, 32'h0, 32'h0);
    chk("pendbit", rd[ST_PEND_BIT], 1);
    pendIn <= 0;
    $display("resume test done");
  endtask : t_resume

  // host access into the protected region is never granted
  task automatic t_host();
    req <= 1; inFact <= 1;
    repeat (3) @(negedge clock);
    chk("blocked", hostFlashGrant, 0);
    @(posedge clock);
    inFact <= 0;
    repeat (3) @(negedge clock);
    chk("granted", hostFlashGrant, 1);
    @(posedge clock);
    req <= 0;
    $display("host access test done");
  endtask : t_host

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clock);
    t_decode();
    t_hold();
    t_break(1'b1);
    t_break(1'b0);
    t_pin_restore();
    t_reg_restore();
    t_resume();
    t_host();
    give_verdict();
  end

  // watchdog: the tests need a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    give_verdict();
  end
endmodule : boot_strap_mode_select_test
